// [src/osf_pkg.sv]
// Purpose: Shared constants and types of the output short-fault flag bank.
// Assumes: One 25 MHz clock domain and an AHB-Lite register port.
// Notes: Register indices are word indices; the byte address is four times the index.
`default_nettype none

package osf_pkg;

   // Number of output channels covered: six groups of three.
   localparam int unsigned OSF_CHANNELS = 18;
   localparam int unsigned OSF_GROUP_WIDTH = 3;
   localparam int unsigned OSF_SYNC_STAGES = 2;

   // Register indices; byte address = index * 4.
   localparam logic [29:0] OSF_IDX_GROUPS_ONE_TWO = 30'h0000_00AB;
   localparam logic [29:0] OSF_IDX_GROUPS_THREE_FOUR = 30'h0000_00AC;
   localparam logic [29:0] OSF_IDX_GROUPS_FIVE_SIX = 30'h0000_00AD;
   localparam logic [29:0] OSF_IDX_IRQ_STATUS = 30'h0000_00B0;
   localparam logic [29:0] OSF_IDX_IRQ_MASK = 30'h0000_00B1;

   // Field positions inside one flag register.
   localparam int unsigned OSF_LOW_GROUP_POS = 0;
   localparam int unsigned OSF_HIGH_GROUP_POS = 4;

   // Values after reset.
   localparam logic [7:0] OSF_FLAG_REG_RESET = 8'h00;
   localparam logic [17:0] OSF_FLAGS_RESET = 18'h00000;
   localparam logic [17:0] OSF_IRQ_STATUS_RESET = 18'h00000;
   localparam logic [17:0] OSF_IRQ_MASK_RESET = 18'h00000;
   localparam logic [31:0] OSF_RDATA_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      OSF_SEL_NONE,
      OSF_SEL_ONE_TWO,
      OSF_SEL_THREE_FOUR,
      OSF_SEL_FIVE_SIX,
      OSF_SEL_IRQ_STATUS,
      OSF_SEL_IRQ_MASK
   } osf_sel_t;

   // Captured address phase, carried into the data phase.
   typedef struct packed {
      logic valid;
      logic write;
      osf_sel_t sel;
   } osf_dphase_t;

   // Per-channel short flags, channel 0 of each group in the low bit.
   typedef struct packed {
      logic [2:0] group_six;
      logic [2:0] group_five;
      logic [2:0] group_four;
      logic [2:0] group_three;
      logic [2:0] group_two;
      logic [2:0] group_one;
   } osf_flags_t;

endpackage

`default_nettype wire

// [src/osf_sync.sv]
// Purpose: Two-stage synchroniser for the short-circuit detector levels.
// Assumes: Detector outputs are asynchronous levels from the analogue side.
// Notes: The first stage is read only by the second stage.
`default_nettype none

module osf_sync
   import osf_pkg::*;
#(
   parameter int unsigned WIDTH = OSF_CHANNELS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta;
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta <= 1'b0;
               sync_out[i] <= 1'b0;
            end else begin
               meta <= async_in[i];
               sync_out[i] <= meta;
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// [src/osf_short_flags.sv]
// Purpose: Read-only output short-fault flag bank for eighteen channels with interrupt.
// Assumes: Single AHB-Lite slave, zero wait states, word transfers only.
// Notes: Flags mirror the synchronised detector levels; rising edges raise sticky status bits.
`default_nettype none

// Summary of operation
// - Register at index ABh packs groups one and two; bits 7,3 zero; resets zero.
// - Register at index ACh packs groups three and four; bits 7,3 zero; resets zero.
// - Register at index ADh packs groups five and six; bits 7,3 zero; resets zero.
// - A flag reads one while its channel's short fault is detected.
// - A flag reads zero without a detected fault, and after reset.
module osf_short_flags
   import osf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [17:0] short_detect,
   output logic irq
);

   // Full decode; a misaligned or unknown address selects nothing.
   function automatic osf_sel_t osf_decode(input logic [31:0] addr);
      osf_sel_t sel;
      sel = OSF_SEL_NONE;
      if (addr[1:0] == 2'h0) begin
         case (addr[31:2])
            OSF_IDX_GROUPS_ONE_TWO: sel = OSF_SEL_ONE_TWO;
            OSF_IDX_GROUPS_THREE_FOUR: sel = OSF_SEL_THREE_FOUR;
            OSF_IDX_GROUPS_FIVE_SIX: sel = OSF_SEL_FIVE_SIX;
            OSF_IDX_IRQ_STATUS: sel = OSF_SEL_IRQ_STATUS;
            OSF_IDX_IRQ_MASK: sel = OSF_SEL_IRQ_MASK;
            default: sel = OSF_SEL_NONE;
         endcase
      end
      return sel;
   endfunction

   // Places two channel groups into one byte with reserved bits 7 and 3 at zero.
   function automatic logic [7:0] osf_pack(input logic [2:0] low_grp, input logic [2:0] high_grp);
      logic [7:0] b;
      b = OSF_FLAG_REG_RESET;
      b[OSF_LOW_GROUP_POS +: OSF_GROUP_WIDTH] = low_grp;
      b[OSF_HIGH_GROUP_POS +: OSF_GROUP_WIDTH] = high_grp;
      return b;
   endfunction

   logic [17:0] det_sync;
   osf_flags_t flags;
   logic [17:0] irq_status;
   logic [17:0] irq_mask;
   logic [17:0] next_irq_status;
   logic [17:0] fault_rise;
   logic [17:0] status_clear;
   osf_dphase_t dphase;
   osf_sel_t addr_sel;
   logic addr_take;
   logic wr_en;
   logic [31:0] read_word;

   osf_sync #(
      .WIDTH(OSF_CHANNELS)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(short_detect),
      .sync_out(det_sync)
   );

   // The slave never stalls and never errors.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   assign addr_sel = osf_decode(haddr);
   assign addr_take = hsel && hready && htrans[1];
   assign wr_en = dphase.valid && dphase.write;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dphase <= '{valid: 1'b0, write: 1'b0, sel: OSF_SEL_NONE};
      end else if (hready) begin
         dphase <= '{valid: addr_take, write: hwrite, sel: addr_sel};
      end
   end

   // Flags follow the detectors only; no bus path reaches them.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= OSF_FLAGS_RESET;
      end else begin
         flags <= det_sync;
      end
   end

   // A new fault is caught one cycle earlier than the flag shows it, so both land together.
   assign fault_rise = det_sync & ~flags;
   assign status_clear = (wr_en && dphase.sel == OSF_SEL_IRQ_STATUS) ? hwdata[17:0] : '0;
   // A rising fault in the cycle of its clear keeps the bit set.
   assign next_irq_status = (irq_status & ~status_clear) | fault_rise;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= OSF_IRQ_STATUS_RESET;
      end else begin
         irq_status <= next_irq_status;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask <= OSF_IRQ_MASK_RESET;
      end else if (wr_en && dphase.sel == OSF_SEL_IRQ_MASK) begin
         irq_mask <= hwdata[17:0];
      end
   end

   assign irq = |(irq_status & irq_mask);

   always_comb begin
      read_word = OSF_RDATA_RESET;
      case (addr_sel)
         OSF_SEL_ONE_TWO: read_word[7:0] = osf_pack(flags.group_one, flags.group_two);
         OSF_SEL_THREE_FOUR: read_word[7:0] = osf_pack(flags.group_three, flags.group_four);
         OSF_SEL_FIVE_SIX: read_word[7:0] = osf_pack(flags.group_five, flags.group_six);
         OSF_SEL_IRQ_STATUS: read_word[17:0] = irq_status;
         OSF_SEL_IRQ_MASK: read_word[17:0] = irq_mask;
         default: read_word = OSF_RDATA_RESET;
      endcase
   end

   // Read data is loaded at the address-phase edge so it stands through the data phase.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= OSF_RDATA_RESET;
      end else if (addr_take && !hwrite) begin
         hrdata <= read_word;
      end
   end

   // Checks.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   logic after_reset;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         after_reset <= 1'b0;
      end else begin
         after_reset <= 1'b1;
      end
   end

   sequence rd_take(osf_sel_t s);
      addr_take && !hwrite && addr_sel == s;
   endsequence

   rd_one_two_a:
   assert property (rd_take(OSF_SEL_ONE_TWO) |=> hrdata ==
      {24'h000000, 1'b0, $past(flags.group_two), 1'b0, $past(flags.group_one)})
      else $error("groups one and two register read is wrong");

   rd_three_four_a:
   assert property (rd_take(OSF_SEL_THREE_FOUR) |=> (hrdata[31:8] == 24'h000000)
      && !hrdata[7] && !hrdata[3] && hrdata[6:4] == $past(flags.group_four)
      && hrdata[2:0] == $past(flags.group_three))
      else $error("groups three and four register read is wrong");

   rd_five_six_a:
   assert property (rd_take(OSF_SEL_FIVE_SIX) ##1 (!hwrite || !addr_take)
      |-> hrdata[7:0] == osf_pack($past(flags.group_five), $past(flags.group_six))
      && hrdata[31:8] == 24'h000000)
      else $error("groups five and six register read is wrong");

   flag_follow_a:
   assert property ((after_reset && $stable(short_detect)) [*3] |=> flags == $past(short_detect))
      else $error("flag does not follow a steady detector level");

   reset_clean_a:
   assert property (!after_reset |-> flags == OSF_FLAGS_RESET && hrdata == OSF_RDATA_RESET)
      else $error("flags or read data not zero after reset");

   write_ignored_a:
   assert property (wr_en && (dphase.sel == OSF_SEL_ONE_TWO ||
      dphase.sel == OSF_SEL_THREE_FOUR || dphase.sel == OSF_SEL_FIVE_SIX)
      |=> flags == $past(det_sync))
      else $error("host write disturbed the flags");

   status_sticky_a:
   assert property ((|fault_rise) |=> (irq_status & $past(fault_rise)) == $past(fault_rise))
      else $error("rising fault did not set its status bit");

   irq_level_a:
   assert property ((irq_status & irq_mask) == 18'h00000 |-> !irq)
      else $error("interrupt high with no unmasked status bit");

   bus_okay_a:
   assert property (addr_take |=> hreadyout && !hresp)
      else $error("slave stalled or answered with an error");

   // Flat view of the flag struct so that checks can pick single channels.
   logic [17:0] flag_bits;
   assign flag_bits = flags;

   rd_status_a:
   assert property (rd_take(OSF_SEL_IRQ_STATUS) |=> hrdata == {14'h0000, $past(irq_status)})
      else $error("status register read is wrong");

   rd_mask_a:
   assert property (rd_take(OSF_SEL_IRQ_MASK) |=> hrdata == {14'h0000, $past(irq_mask)})
      else $error("mask register read is wrong");

   rd_unmapped_a:
   assert property (rd_take(OSF_SEL_NONE) |=> hrdata == OSF_RDATA_RESET)
      else $error("unmapped address did not read zero");

   rd_reserved_a:
   assert property (addr_take && !hwrite && (addr_sel == OSF_SEL_ONE_TWO
      || addr_sel == OSF_SEL_THREE_FOUR || addr_sel == OSF_SEL_FIVE_SIX)
      |=> hrdata[31:7] == 25'h0 && !hrdata[3])
      else $error("reserved bit of a flag register read as one");

   rdata_hold_a:
   assert property (!(addr_take && !hwrite) |=> hrdata == $past(hrdata))
      else $error("read data changed without a read");

   wr_no_read_a:
   assert property (addr_take && hwrite |=> hrdata == $past(hrdata))
      else $error("a write disturbed the read data");

   dphase_idle_a:
   assert property (!addr_take |=> !dphase.valid)
      else $error("data phase opened without a transfer");

   mask_write_a:
   assert property (wr_en && dphase.sel == OSF_SEL_IRQ_MASK
      |=> irq_mask == $past(hwdata[17:0]))
      else $error("mask write did not land");

   mask_hold_a:
   assert property (!(wr_en && dphase.sel == OSF_SEL_IRQ_MASK)
      |=> irq_mask == $past(irq_mask))
      else $error("mask changed without a write");

   status_clear_a:
   assert property (wr_en && dphase.sel == OSF_SEL_IRQ_STATUS
      |=> (irq_status & $past(status_clear & ~fault_rise)) == 18'h00000)
      else $error("status bit survived its clear");

   set_wins_a:
   assert property (|(fault_rise & status_clear)
      |=> (irq_status & $past(fault_rise & status_clear)) == $past(fault_rise & status_clear))
      else $error("clear overrode a fault in the same cycle");

   irq_on_a:
   assert property ((irq_status & irq_mask) != 18'h00000 |-> irq)
      else $error("interrupt low with an unmasked status bit");

   // Per-channel flag and status checks, one copy for each detector input.
   genvar ch;
   generate
      for (ch = 0; ch < OSF_CHANNELS; ch++) begin : g_chan
         chan_rise_a:
         assert property (det_sync[ch] && !flag_bits[ch] |=> flag_bits[ch] && irq_status[ch])
            else $error("channel fault did not raise its flag and status bit");

         chan_drop_a:
         assert property (!det_sync[ch] |=> !flag_bits[ch])
            else $error("channel flag stayed high without a detected fault");

         chan_hold_a:
         assert property (!fault_rise[ch] && !status_clear[ch]
            |=> irq_status[ch] == $past(irq_status[ch]))
            else $error("channel status bit changed with no event");
      end
   endgenerate

   fault_read_c:
   cover property (rd_take(OSF_SEL_ONE_TWO) ##1 hrdata[7:0] != 8'h00);

   irq_raise_c:
   cover property (!irq ##1 irq);

   status_clear_c:
   cover property (irq ##1 wr_en && dphase.sel == OSF_SEL_IRQ_STATUS ##1 !irq);

   flag_write_c:
   cover property (wr_en && dphase.sel == OSF_SEL_FIVE_SIX && hwdata[7:0] != 8'h00);

endmodule

`default_nettype wire

// [verification/osf_short_flags_tb.sv]
// Purpose: Self-checking bench for the short-fault flag bank and its interrupt.
// Assumes: Zero-wait AHB-Lite slave; detector levels reach the flags three edges later.
// Notes: Four edges are allowed after a detector change so the synchroniser has settled.
`default_nettype none

module tb
   import osf_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [17:0] short_detect = 18'h0;
   logic [31:0] rd;
   wire logic hreadyout;
   wire logic hresp;
   wire logic irq;
   wire logic [31:0] hrdata;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   logic [29:0] idx [3] = '{OSF_IDX_GROUPS_ONE_TWO, OSF_IDX_GROUPS_THREE_FOUR,
      OSF_IDX_GROUPS_FIVE_SIX};

   osf_short_flags u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .short_detect(short_detect),
      .irq(irq));

   always #20 clk = ~clk;

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // A hang in any wait below ends here rather than stalling the run.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_fail++;
         results();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask

   task automatic xfer(input logic [29:0] ix, input logic wr, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {ix, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0);
      chk("hreadyout", {31'h0, hreadyout}, 32'h1);
   endtask

   function automatic logic [31:0] exp_reg(input logic [17:0] s, input int g);
      return {24'h0, 1'b0, s[6*g+3 +: 3], 1'b0, s[6*g +: 3]};
   endfunction

   task automatic settle(input logic [17:0] s);
      short_detect <= s;
      repeat (4) @(posedge clk);
   endtask

   task automatic t_reset();
      for (int g = 0; g < 3; g++) begin
         xfer(idx[g], 1'b0, 32'h0);
         chk("reset flags", rd, 32'h0);
      end
      xfer(OSF_IDX_IRQ_STATUS, 1'b0, 32'h0);
      chk("reset status", rd, 32'h0);
      xfer(OSF_IDX_IRQ_MASK, 1'b0, 32'h0);
      chk("reset mask", rd, 32'h0);
      $display("test reset done");
   endtask

   // Walks one channel at a time, then all at once so reserved bits are exposed.
   task automatic t_map();
      logic [17:0] p;
      for (int k = 0; k < 19; k++) begin
         p = (k == 18) ? 18'h3FFFF : 18'h1 << k;
         settle(p);
         for (int g = 0; g < 3; g++) begin
            xfer(idx[g], 1'b0, 32'h0);
            chk("flag map", rd, exp_reg(p, g));
         end
      end
      $display("test map done");
   endtask

   task automatic t_ro();
      logic [17:0] p;
      p = 18'h15A5C;
      settle(p);
      for (int g = 0; g < 3; g++) begin
         xfer(idx[g], 1'b1, ~exp_reg(p, g));
         xfer(idx[g], 1'b0, 32'h0);
         chk("write ignored", rd, exp_reg(p, g));
      end
      xfer(30'h0, 1'b1, 32'hFFFFFFFF);
      xfer(30'h0, 1'b0, 32'h0);
      chk("unmapped", rd, 32'h0);
      settle(18'h0);
      for (int g = 0; g < 3; g++) begin
         xfer(idx[g], 1'b0, 32'h0);
         chk("flag drop", rd, 32'h0);
      end
      $display("test read-only done");
   endtask

   task automatic t_irq();
      xfer(OSF_IDX_IRQ_STATUS, 1'b1, 32'h3FFFF);
      xfer(OSF_IDX_IRQ_MASK, 1'b1, 32'h80);
      @(posedge clk);
      chk("irq idle", {31'h0, irq}, 32'h0);
      settle(18'h80);
      @(posedge clk);
      chk("irq raised", {31'h0, irq}, 32'h1);
      xfer(OSF_IDX_IRQ_STATUS, 1'b0, 32'h0);
      chk("status", rd, 32'h80);
      settle(18'h0);
      @(posedge clk);
      chk("irq sticky", {31'h0, irq}, 32'h1);
      xfer(OSF_IDX_IRQ_STATUS, 1'b1, 32'h80);
      @(posedge clk);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      settle(18'h100);
      @(posedge clk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      xfer(OSF_IDX_IRQ_STATUS, 1'b0, 32'h0);
      chk("masked status", rd, 32'h100);
      // The clear and a new fault meet at one edge; the fault must survive.
      short_detect <= 18'h180;
      xfer(OSF_IDX_IRQ_STATUS, 1'b1, 32'h180);
      @(posedge clk);
      chk("set beats clear", {31'h0, irq}, 32'h1);
      xfer(OSF_IDX_IRQ_STATUS, 1'b0, 32'h0);
      chk("status after race", rd, 32'h80);
      $display("test interrupt done");
   endtask

   // Mid-run reset with every detector high: all state restarts from zero.
   task automatic t_rst();
      xfer(OSF_IDX_IRQ_MASK, 1'b1, 32'h3FFFF);
      settle(18'h3FFFF);
      @(posedge clk);
      chk("irq before reset", {31'h0, irq}, 32'h1);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      xfer(idx[0], 1'b0, 32'h0);
      chk("flags after reset", rd, 32'h0);
      xfer(OSF_IDX_IRQ_MASK, 1'b0, 32'h0);
      chk("mask after reset", rd, 32'h0);
      @(posedge clk);
      chk("irq after reset", {31'h0, irq}, 32'h0);
      for (int g = 0; g < 3; g++) begin
         xfer(idx[g], 1'b0, 32'h0);
         chk("flags back", rd, 32'h77);
      end
      $display("test mid-run reset done");
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_map();
      t_ro();
      t_irq();
      t_rst();
      results();
   end
endmodule

`default_nettype wire
